/* pkg/eivs_regs.svh */
// register offsets, field positions, reset values and timing counts of the interrupt block
`ifndef EIVS_REGS_SVH
`define EIVS_REGS_SVH

// i/o space offsets
`define EIVS_OFS_CSR          6'h34
`define EIVS_OFS_SENSE        6'h35
`define EIVS_OFS_FLAG         6'h3A
`define EIVS_OFS_GIC          6'h3B

// control_status_sense fields
`define EIVS_BIT_SENSE_TWO    6
// sense_control fields
`define EIVS_BIT_SENSE_ONE    2
`define EIVS_BIT_SENSE_ZERO   0
// general_irq_control fields
`define EIVS_BIT_EN_ONE       7
`define EIVS_BIT_EN_ZERO      6
`define EIVS_BIT_EN_TWO       5
`define EIVS_BIT_PLACE        1
`define EIVS_BIT_UNLOCK       0

// reset values
`define EIVS_RST_REG          8'h00

// unlock window length in core cycles
`define EIVS_UNLOCK_CYC       3'h4

`endif

/* pkg/eivs_pkg.sv */
// types shared by the interrupt and vector placement block
package eivs_pkg;

  // sense selections for the two full inputs
  typedef enum logic [1:0]
  {
    EIVS_SNS_LOW  = 2'h0,
    EIVS_SNS_ANY  = 2'h1,
    EIVS_SNS_FALL = 2'h2,
    EIVS_SNS_RISE = 2'h3
  } eivs_sense_t;

  // vector change sequence states, gray coded
  typedef enum logic [1:0]
  {
    EIVS_VC_IDLE = 2'h0,
    EIVS_VC_OPEN = 2'h1,
    EIVS_VC_HOLD = 2'h3
  } eivs_vc_t;

  // i/o register port from the core
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } eivs_io_t;

endpackage

/* rtl/eivs_detect.sv */
// per pin sampler and edge / level detector
`timescale 1ns/10ps
module eivs_detect
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // pin and mode
  input  wire logic       pin,
  input  wire logic [1:0] sense,
  // result
  output logic            edge_evt,
  output logic            level_low
);

  logic samp_r;       // sampled pin
  logic samp_nxt;
  logic prev_r;       // previous sample
  logic prev_nxt;

  // sample first, then compare two samples
  always_comb
  begin
    samp_nxt = pin; // see (RL17)
    prev_nxt = samp_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      samp_r <= 1'b1;
      prev_r <= 1'b1;
    end
    else
    begin
      samp_r <= samp_nxt;
      prev_r <= prev_nxt;
    end
  end

  // decode the mode; the pin direction does not matter here
  always_comb
  begin
    level_low = ~samp_r; // see (RL8)
    case (eivs_pkg::eivs_sense_t'(sense))
      eivs_pkg::EIVS_SNS_ANY:  edge_evt = samp_r ^ prev_r;
      eivs_pkg::EIVS_SNS_FALL: edge_evt = prev_r & ~samp_r;
      eivs_pkg::EIVS_SNS_RISE: edge_evt = ~prev_r & samp_r;
      default:                 edge_evt = 1'b0;
    endcase
  end

endmodule

/* rtl/eivs_top.sv */
// external interrupt detection and vector table placement control
// Functional notes
// (RL1) placement bit picks application or boot vectors
// (RL2) software unlocks then writes placement within four
// (RL3) unlock clears after four cycles or placement write
// (RL4) interrupts blocked from unlock until after next instruction
// (RL5) no placement write: block four cycles only; blocked here for five, the unlock cycle plus the four-cycle window
// (RL6) blocking leaves global enable untouched
// (RL7) boot lock bits block interrupts per section
// (RL8) pin triggers even when driven as output
// (RL9) inputs zero/one edge and level; two edge only
// (RL10) low level keeps requesting while pin low
// (RL11) edges need i/o clock; level wakes sleep
// (RL12) power-down wake samples level twice on watchdog clock
// (RL13) level gone before startup: wake, no interrupt
// (RL14) input one needs global and own enable
// (RL15) input one sense at bits 3:2
// (RL16) input zero sense at bits 1:0
// (RL17) pin sampled before edge detection
// (RL18) source holds low level until instruction ends
// (RL19) input two sense bit: fall zero, rise one
// (RL20) enables at bits 7, 6, 5 for one, zero, two
// (RL21) flags set on event, clear by ack or one
// (RL22) placement write without unlock is ignored
// (RL23) request is detect and enable and global, unblocked
`timescale 1ns/10ps
`include "eivs_regs.svh"
module eivs_top
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // core i/o register port
  input  wire eivs_pkg::eivs_io_t io,
  output logic [7:0]             io_rdata,
  // core status
  input  wire logic              global_ie,
  input  wire logic              instr_done,
  input  wire logic              exec_in_boot,
  input  wire logic [2:0]        irq_ack,
  // sleep and wake
  input  wire logic              io_clk_on,
  input  wire logic              wdt_tick,
  input  wire logic              startup_done,
  // lock bits
  input  wire logic              app_boot_lock,
  input  wire logic              boot_section_lock,
  // pins
  input  wire logic              ext_irq_zero,
  input  wire logic              ext_irq_one,
  input  wire logic              ext_irq_two,
  // to the core
  output logic [2:0]             irq_req,
  output logic                   vector_placement,
  output logic                   wake_req
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [1:0] sense_zero_r, sense_zero_nxt;   // input zero mode
  logic [1:0] sense_one_r,  sense_one_nxt;    // input one mode
  logic       sense_two_r,  sense_two_nxt;    // input two edge
  logic [2:0] en_r, en_nxt;                   // enables {two, one, zero} order below
  logic [2:0] flag_r, flag_nxt;               // edge flags index 0..2
  logic       place_r, place_nxt;             // vector placement
  logic       unlock_r, unlock_nxt;           // change unlock bit
  logic [2:0] ucnt_r, ucnt_nxt;               // unlock countdown
  eivs_pkg::eivs_vc_t vc_r, vc_nxt;           // blocking sequence
  logic [7:0] rdata_r, rdata_nxt;             // read data register
  logic [2:0] req_r, req_nxt;                 // request outputs
  logic       wake_r, wake_nxt;               // wake output
  logic       wsmp_r, wsmp_nxt;               // last watchdog level sample
  logic       wlatch_r, wlatch_nxt;           // wake seen

  // address match, used for every register
  function automatic logic hit(input logic [5:0] ofs);
    hit = io.wr && (io.addr == ofs);
  endfunction

  // ****************************************************************
  // detectors
  // ****************************************************************
  logic [2:0] pins;
  logic [1:0] sns [3];
  logic [2:0] edge_evt;
  logic [2:0] lvl_low;
  logic [2:0] is_level;

  assign pins = {ext_irq_two, ext_irq_one, ext_irq_zero};
  assign sns[0] = sense_zero_r;
  assign sns[1] = sense_one_r;
  // input two only knows falling and rising
  assign sns[2] = sense_two_r ? 2'h3 : 2'h2; // see (RL19) (RL9)

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_det
      eivs_detect u_det
      (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin       (pins[gi]),
        .sense     (sns[gi]),
        .edge_evt  (edge_evt[gi]),
        .level_low (lvl_low[gi])
      );
      assign is_level[gi] = (sns[gi] == 2'h0);
    end
  endgenerate

  // ****************************************************************
  // register writes and vector change sequence
  // ****************************************************************
  // the global enable is only read, never written, by the blocking logic
  always_comb
  begin
    logic gw;
    gw = hit(`EIVS_OFS_GIC);
    sense_zero_nxt = sense_zero_r;
    sense_one_nxt  = sense_one_r;
    sense_two_nxt  = sense_two_r;
    en_nxt         = en_r;
    place_nxt      = place_r;
    unlock_nxt     = unlock_r;
    ucnt_nxt       = ucnt_r;
    vc_nxt         = vc_r;
    if (hit(`EIVS_OFS_SENSE))
    begin
      sense_one_nxt  = io.wdata[`EIVS_BIT_SENSE_ONE+:2];   // see (RL15)
      sense_zero_nxt = io.wdata[`EIVS_BIT_SENSE_ZERO+:2];  // see (RL16)
    end
    if (hit(`EIVS_OFS_CSR))
      sense_two_nxt = io.wdata[`EIVS_BIT_SENSE_TWO];
    if (gw)
      en_nxt = {io.wdata[`EIVS_BIT_EN_TWO], io.wdata[`EIVS_BIT_EN_ONE],
                io.wdata[`EIVS_BIT_EN_ZERO]};  // see (RL20)
    // countdown of the open window
    if (unlock_r)
    begin
      if (ucnt_r == 3'h1)
        unlock_nxt = 1'b0;  // see (RL3)
      ucnt_nxt = ucnt_r - 3'h1;
    end
    case (vc_r)
      eivs_pkg::EIVS_VC_IDLE:
      begin
        if (gw && io.wdata[`EIVS_BIT_UNLOCK])
        begin
          unlock_nxt = 1'b1;
          ucnt_nxt   = `EIVS_UNLOCK_CYC;
          vc_nxt     = eivs_pkg::EIVS_VC_OPEN;  // see (RL4)
        end
      end
      eivs_pkg::EIVS_VC_OPEN:
      begin
        if (gw && !io.wdata[`EIVS_BIT_UNLOCK])
        begin
          // placement taken only inside the window
          place_nxt  = io.wdata[`EIVS_BIT_PLACE];  // see (RL2) (RL22)
          unlock_nxt = 1'b0;                       // see (RL3)
          vc_nxt     = eivs_pkg::EIVS_VC_HOLD;
        end
        else if (ucnt_r == 3'h1)
          vc_nxt = eivs_pkg::EIVS_VC_IDLE;         // see (RL5)
      end
      eivs_pkg::EIVS_VC_HOLD:
      begin
        // released after the instruction that follows the write
        if (instr_done)
          vc_nxt = eivs_pkg::EIVS_VC_IDLE;         // see (RL4)
      end
      default:
        vc_nxt = eivs_pkg::EIVS_VC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sense_zero_r <= 2'h0;
      sense_one_r  <= 2'h0;
      sense_two_r  <= 1'b0;
      en_r         <= 3'h0;
      place_r      <= 1'b0;
      unlock_r     <= 1'b0;
      ucnt_r       <= 3'h0;
      vc_r         <= eivs_pkg::EIVS_VC_IDLE;
    end
    else
    begin
      sense_zero_r <= sense_zero_nxt;
      sense_one_r  <= sense_one_nxt;
      sense_two_r  <= sense_two_nxt;
      en_r         <= en_nxt;
      place_r      <= place_nxt;
      unlock_r     <= unlock_nxt;
      ucnt_r       <= ucnt_nxt;
      vc_r         <= vc_nxt;
    end
  end

  // ****************************************************************
  // flags, requests and wake
  // ****************************************************************
  logic blocked;
  // blocked in the unlock cycle itself as well as the window
  assign blocked = (vc_r != eivs_pkg::EIVS_VC_IDLE)
                 || (hit(`EIVS_OFS_GIC) && io.wdata[`EIVS_BIT_UNLOCK]
                     && vc_r == eivs_pkg::EIVS_VC_IDLE)          // see (RL4)
                 || (place_r && app_boot_lock && !exec_in_boot)  // see (RL7)
                 || (!place_r && boot_section_lock && exec_in_boot);

  always_comb
  begin
    logic [2:0] clr;
    logic       lvl_any;  // an enabled input in level mode sees a low
    logic       wset;     // second watchdog sample confirms the level
    clr = irq_ack | (hit(`EIVS_OFS_FLAG) ?
          {io.wdata[`EIVS_BIT_EN_TWO], io.wdata[`EIVS_BIT_EN_ONE],
           io.wdata[`EIVS_BIT_EN_ZERO]} : 3'h0);
    lvl_any = |(lvl_low & is_level & en_r);
    wset    = wdt_tick && wsmp_r && lvl_any;
    for (int i = 0; i < 3; i++)
    begin
      // edges need the i/o clock; a new event wins over a clear
      if (is_level[i])
        flag_nxt[i] = 1'b0;                                   // see (RL21)
      else if (edge_evt[i] && io_clk_on)
        flag_nxt[i] = 1'b1;                                   // see (RL11) (RL21)
      else if (clr[i])
        flag_nxt[i] = 1'b0;
      else
        flag_nxt[i] = flag_r[i];
      // level keeps asking while low; gated by own and global enable
      req_nxt[i] = (is_level[i] ? lvl_low[i] : flag_r[i])     // see (RL10)
                   && en_r[i] && global_ie && !blocked;       // see (RL14) (RL23) (RL6)
    end
    // power-down wake: one watchdog sample is remembered, the next confirms it;
    // a glitch shorter than a watchdog period therefore cannot wake the part
    wsmp_nxt = wsmp_r;
    if (wdt_tick)
      wsmp_nxt = lvl_any;
    else if (startup_done)
      wsmp_nxt = 1'b0;
    // a confirmed wake stands to the end of start-up even if the level is gone
    wlatch_nxt = wlatch_r;
    if (wset)
      wlatch_nxt = 1'b1;                                      // see (RL12)
    else if (startup_done)
      wlatch_nxt = 1'b0;                                      // see (RL13)
    wake_nxt = wlatch_nxt;                                    // see (RL11) (RL13)
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flag_r   <= 3'h0;
      req_r    <= 3'h0;
      wsmp_r   <= 1'b0;
      wlatch_r <= 1'b0;
      wake_r   <= 1'b0;
    end
    else
    begin
      flag_r   <= flag_nxt;
      req_r    <= req_nxt;
      wsmp_r   <= wsmp_nxt;
      wlatch_r <= wlatch_nxt;
      wake_r   <= wake_nxt;
    end
  end

  // ****************************************************************
  // read back
  // ****************************************************************
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (io.rd)
    begin
      rdata_nxt = `EIVS_RST_REG;
      case (io.addr)
        `EIVS_OFS_CSR:   rdata_nxt[`EIVS_BIT_SENSE_TWO] = sense_two_r;
        `EIVS_OFS_SENSE: rdata_nxt[3:0] = {sense_one_r, sense_zero_r};
        `EIVS_OFS_FLAG:  rdata_nxt[7:5] = {flag_r[1], flag_r[0], flag_r[2]};
        `EIVS_OFS_GIC:   rdata_nxt = {en_r[1], en_r[0], en_r[2], 3'h0, place_r, unlock_r};
        default:         rdata_nxt = `EIVS_RST_REG;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_r <= `EIVS_RST_REG;
    else
      rdata_r <= rdata_nxt;
  end

  assign io_rdata         = rdata_r;
  assign irq_req          = req_r;
  assign vector_placement = place_r;  // see (RL1)
  assign wake_req         = wake_r;

endmodule

/* sim/eivs_asserts.sv */
// concurrent checks on the interrupt block ports
`timescale 1ns/10ps
module eivs_asserts
(
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // core side
  input wire eivs_pkg::eivs_io_t io,
  input wire logic [7:0]         io_rdata,
  input wire logic               global_ie,
  input wire logic               exec_in_boot,
  input wire logic               app_boot_lock,
  input wire logic               startup_done,
  // results
  input wire logic [2:0]         irq_req,
  input wire logic               vector_placement,
  input wire logic               wake_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ****************************************
  // unlock and placement writes, then reset, global enable, boot lock, wake and unmapped read checks
  // ****************************************
  sequence s_unl;
    io.wr && io.addr == 6'h3B && io.wdata[0];
  endsequence
  sequence s_plc;
    io.wr && io.addr == 6'h3B && !io.wdata[0];
  endsequence
  property p_rst;
    $fell(rst) |-> irq_req == 3'h0 && !vector_placement && !wake_req;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  // a global enable held low for two cycles leaves no request standing
  property p_gie;
    !global_ie && $past(!global_ie) |-> irq_req == 3'h0;
  endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_unl_blk;
    s_unl |=> ##1 (irq_req == 3'h0) [*3];
  endproperty
  a_unl_blk: assert property (p_unl_blk) else $error("request while unlocked");
  property p_plc_val;
    s_unl ##[1:4] s_plc |=> vector_placement == $past(io.wdata[1]);
  endproperty
  a_plc_val: assert property (p_plc_val) else $error("placement not taken");
  // a write five cycles after the unlock must find the window already shut
  property p_unl_exp;
    s_unl ##1 (!io.wr) [*4] ##1 s_plc |=> $stable(vector_placement);
  endproperty
  a_unl_exp: assert property (p_unl_exp) else $error("placement after window");
  property p_boot_app;
    (vector_placement && app_boot_lock && !exec_in_boot) [*2] |-> irq_req == 3'h0;
  endproperty
  a_boot_app: assert property (p_boot_app) else $error("request in locked app");
  property p_wake;
    wake_req && !startup_done |=> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("wake dropped early");
  property p_unmap;
    io.rd && !(io.addr inside {6'h34, 6'h35, 6'h3A, 6'h3B}) |=> io_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind eivs_top eivs_asserts u_chk (.clk_sys, .rst, .io, .io_rdata, .global_ie, .exec_in_boot,
  .app_boot_lock, .startup_done, .irq_req, .vector_placement, .wake_req);

/* sim/eivs_far_model.sv */
// far side model: pins with pull-ups and the core instruction pace
`timescale 1ns/10ps
module eivs_far_model
(
  // clock
  input wire logic clk_sys,
  // pins and core pace
  output logic [2:0] pins,
  output logic       instr_done
);
  logic [1:0] pace_r = 2'h0; // instruction length counter
  initial pins = 3'h7;       // pull-ups hold idle pins high
  // software drives its own pin as an output to raise a request
  task automatic drive(input int ch, input logic v);
    @(posedge clk_sys) #1 pins[ch] = v;
  endtask
  // one instruction every four cycles; callers hold a low level for several
  always @(posedge clk_sys) #1 pace_r <= pace_r + 2'h1;
  assign instr_done = (pace_r == 2'h3);
endmodule

/* sim/tb.sv */
// self-checking bench for the interrupt and vector placement block
`timescale 1ns/10ps
module tb;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  eivs_pkg::eivs_io_t io = '0;
  logic [7:0]         io_rdata;
  logic               global_ie = 1'b1;
  logic               exec_in_boot = 1'b0;
  logic [2:0]         irq_ack = 3'h0;
  logic               io_clk_on = 1'b1;
  logic               wdt_tick = 1'b0;
  logic               startup_done = 1'b0;
  logic               app_boot_lock = 1'b0;
  logic               boot_section_lock = 1'b0;
  logic [2:0]         pins;
  logic [2:0]         irq_req;
  logic               instr_done;
  logic               vector_placement;
  logic               wake_req;
  int                 bad_count = 0;
  int                 num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  eivs_far_model far (.clk_sys, .pins, .instr_done);
  eivs_top dut (.clk_sys, .rst, .io, .io_rdata, .global_ie, .instr_done, .exec_in_boot,
    .irq_ack, .io_clk_on, .wdt_tick, .startup_done, .app_boot_lock, .boot_section_lock,
    .ext_irq_zero(pins[0]), .ext_irq_one(pins[1]), .ext_irq_two(pins[2]),
    .irq_req, .vector_placement, .wake_req);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // strobes last one cycle, so back to back writes are two cycles apart
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1 io = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys) #1 io.wr = 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_sys) #1 io = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys) #1 io.rd = 1'b0;
    chk("rdata", io_rdata, exp);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rdc(6'h34, 8'h00);
    rdc(6'h35, 8'h00);
    rdc(6'h3A, 8'h00);
    rdc(6'h3B, 8'h00);
    rdc(6'h10, 8'h00);
    wr(6'h35, 8'h0F);
    rdc(6'h35, 8'h0F);
  endtask
  // the late write lands five cycles after the unlock, one past the window
  task automatic t_vec();
    wr(6'h3B, 8'h02);
    chk("place", 8'(vector_placement), 8'h00);
    wr(6'h3B, 8'h01);
    wr(6'h3B, 8'h02);
    cyc(1);
    chk("place", 8'(vector_placement), 8'h01);
    rdc(6'h3B, 8'h02);
    wr(6'h3B, 8'h03);
    rdc(6'h3B, 8'h03);
    cyc(1);
    wr(6'h3B, 8'h00);
    cyc(1);
    chk("place", 8'(vector_placement), 8'h01);
    rdc(6'h3B, 8'h02);
  endtask
  task automatic t_blk();
    wr(6'h35, 8'h02);
    wr(6'h3B, 8'h40);
    global_ie = 1'b0;
    far.drive(0, 1'b0);
    cyc(5);
    chk("req", 8'(irq_req), 8'h00);
    global_ie = 1'b1;
    cyc(2);
    chk("req", 8'(irq_req), 8'h01);
    wr(6'h3B, 8'h41);
    cyc(1);
    chk("req", 8'(irq_req), 8'h00);
    cyc(3);
    chk("req", 8'(irq_req), 8'h00);
    cyc(1);
    chk("req", 8'(irq_req), 8'h01);
    irq_ack = 3'h1;
    cyc(1);
    irq_ack = 3'h0;
    cyc(2);
    chk("req", 8'(irq_req), 8'h00);
    far.drive(0, 1'b1);
  endtask
  // every sense code on every input; input two has edges only
  task automatic t_sense();
    logic [7:0] en;
    logic [1:0] m;
    bit         f;
    bit         r;
    for (int ch = 0; ch < 3; ch++)
      for (int k = (ch == 2) ? 2 : 0; k < 4; k++)
      begin
        m = 2'(k);
        en = 8'h20 << ((ch == 2) ? 0 : ch + 1);
        f = (m != 2'h3);
        r = (m == 2'h1 || m == 2'h3);
        if (ch == 2)
          wr(6'h34, {1'b0, m[0], 6'h00});
        else
          wr(6'h35, 8'(m) << (2 * ch));
        wr(6'h3B, en);
        wr(6'h3A, en);
        far.drive(ch, 1'b0);
        cyc(5);
        chk("fall", 8'(irq_req[ch]), 8'(f));
        rdc(6'h3A, (f && m != 2'h0) ? en : 8'h00);
        wr(6'h3A, en);
        far.drive(ch, 1'b1);
        cyc(5);
        chk("rise", 8'(irq_req[ch]), 8'(r));
        wr(6'h3A, en);
      end
  endtask
  task automatic t_lock();
    wr(6'h35, 8'h00);
    wr(6'h3B, 8'h40);
    app_boot_lock = 1'b1;
    far.drive(0, 1'b0);
    cyc(5);
    chk("lock", 8'(irq_req), 8'h00);
    exec_in_boot = 1'b1;
    cyc(3);
    chk("lock", 8'(irq_req), 8'h01);
    // vectors back to the application, boot code locked
    app_boot_lock = 1'b0;
    boot_section_lock = 1'b1;
    wr(6'h3B, 8'h41);
    wr(6'h3B, 8'h40);
    cyc(6);
    chk("place", 8'(vector_placement), 8'h00);
    chk("lock", 8'(irq_req), 8'h00);
    exec_in_boot = 1'b0;
    cyc(3);
    chk("lock", 8'(irq_req), 8'h01);
    far.drive(0, 1'b1);
    boot_section_lock = 1'b0;
  endtask
  // the i/o clock stops, so no edge flag can set; the level still drives the request and the watchdog samples
  task automatic t_wake();
    io_clk_on = 1'b0;
    far.drive(0, 1'b0);
    cyc(1);
    repeat (2)
    begin
      wdt_tick = 1'b1;
      cyc(1);
      wdt_tick = 1'b0;
      cyc(3);
    end
    chk("wake", 8'(wake_req), 8'h01);
    // level gone before start-up ends: still awake, but no request
    far.drive(0, 1'b1);
    cyc(3);
    chk("wake", 8'(wake_req), 8'h01);
    chk("req", 8'(irq_req), 8'h00);
    startup_done = 1'b1;
    cyc(1);
    startup_done = 1'b0;
    cyc(1);
    chk("wake", 8'(wake_req), 8'h00);
    io_clk_on = 1'b1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    cyc(3);
    rst = 1'b0;
    t_regs();
    t_vec();
    t_blk();
    t_sense();
    t_lock();
    t_wake();
    end_of_test();
  end
  // the whole run needs well under a thousand cycles; this allows ten thousand
  initial
  begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule
